// File: testbench/ddrio_partner.sv
// link partner model: drives the input pins and records write bursts
`timescale 1ns/1ps
module ddrio_partner (
  input logic core_clk,
  input ddrio_pkg::ddrio_pair_s [7:0] dq_out,
  input ddrio_pkg::ddrio_pair_s dq_oe,
  input logic send_en,
  input logic [15:0] send_word,
  output ddrio_pkg::ddrio_pair_s [7:0] in_pin,
  output logic [15:0] cap_word
);
  import ddrio_pkg::*;
  // start clear so the toggling idle line is never unknown; one driver per port
  ddrio_pair_s [7:0] pin_r = '0;
  logic [15:0] word_r = '0;
  assign in_pin = pin_r;
  assign cap_word = word_r;
  // capture and transfer share one clock
  // pins move just after the edge; an idle line toggles so no stale value is seen
  always @(posedge core_clk) begin
    pin_r <= send_en ? send_word : ~pin_r;
  end
  // record what the write side launched while its data enable is up
  always @(posedge core_clk) begin
    if (dq_oe == 2'h3) begin
      word_r <= dq_out;
    end
  end
endmodule

// File: testbench/tb_ddrio_top.sv
// self-checking bench for the ddr i/o register logic
`timescale 1ns/1ps
module tb_ddrio_top;
  import ddrio_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wr_valid = 1'b0;
  logic [7:0] rise_in = '0;
  logic [7:0] fall_in = '0;
  logic mr = 1'b0;
  logic mf = 1'b0;
  logic [15:0] addr_in = '0;
  logic in_ce = 1'b1;
  ddrio_in_mode_e in_mode = IN_BASIC;
  logic dyn = 1'b0;
  logic [3:0] dcode = '0;
  logic [3:0][7:0] gin = '0;
  logic send_en = 1'b0;
  logic [15:0] send_word = '0;
  ddrio_pair_s [7:0] dq_out, in_pin, gear_out;
  ddrio_pair_s dq_oe, dm_out, dqs_out, dqs_oe, mcp, mcn;
  logic [15:0] addr_out, cap_word;
  logic [7:0] sds, rq, fq;
  logic [1:0][7:0] rqp, fqp;
  logic slow_tick;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int k;
  // write rows: valid, rise half, fall half, mask halves, address
  logic t_val [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0] t_rise [5] = '{8'h01, 8'hFF, 8'h55, 8'h80, 8'hC3};
  logic [7:0] t_fall [5] = '{8'hFE, 8'h00, 8'hAA, 8'h7F, 8'h3C};
  logic t_mr [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic t_mf [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [15:0] t_addr [5] = '{16'h0001, 16'hFFFF, 16'h1234, 16'h8000, 16'hA5A5};

  ddrio_top dut (.core_clk(core_clk), .reset(reset), .wr_valid(wr_valid),
    .rise_edge_data_in(rise_in), .fall_edge_data_in(fall_in), .mask_rise_in(mr),
    .mask_fall_in(mf), .addr_cmd_in(addr_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .dm_out(dm_out), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .mem_clock_pos(mcp),
    .mem_clock_neg(mcn), .addr_cmd_out(addr_out), .strobe_delay_setting(sds),
    .in_pin(in_pin), .in_ce(in_ce), .in_mode(in_mode), .delay_dynamic(dyn),
    .delay_code(dcode), .rise_data_out(rq), .fall_data_out(fq),
    .rise_data_out_pair(rqp), .fall_data_out_pair(fqp), .gear_data_in(gin),
    .gear_out(gear_out), .slow_tick(slow_tick));
  ddrio_partner link (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .send_en(send_en), .send_word(send_word), .in_pin(in_pin), .cap_word(cap_word));

  always #5 core_clk = ~core_clk;
  // hang guard: the whole run needs well under two hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      summarize();
    end
  end
  // ***********************************************************
  // helpers
  // ***********************************************************
  // pack rise and fall halves into pin pairs, fall in the upper bit of each
  function automatic logic [15:0] mk(input logic [7:0] r, input logic [7:0] f);
    for (int b = 0; b < 8; b++) begin
      mk[2*b] = r[b];
      mk[2*b+1] = f[b];
    end
  endfunction
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic send(input logic [7:0] r, input logic [7:0] f, input int n);
    send_en = 1'b1;
    send_word = mk(r, f);
    wait_n(n);
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    wait_n(8);
    chk("dq_oe", 2'h0, dq_oe);
    chk("dqs_oe", 2'h0, dqs_oe);
    chk("slow_tick", 1'b0, slow_tick);
    chk("strobe_delay", 8'(CLK_PERIOD_PS / 4 / DELAY_STEP_PS), sds);
    reset = 1'b0;
    chk("dqs_out", 2'h2, dqs_out);
    chk("clock_pos", 2'h2, mcp);
    chk("clock_neg", 2'h1, mcn);
    // back-to-back write rows with a gap, checked as they leave the pipeline
    for (int i = 0; i < 7; i++) begin
      if (i >= 2) begin
        chk("dq_out", mk(t_rise[i-2], t_fall[i-2]), dq_out);
        chk("dm_out", {t_mf[i-2], t_mr[i-2]}, dm_out);
        chk("dq_oe", {2{t_val[i-2]}}, dq_oe);
      end
      if (i >= 1) chk("addr_cmd_out", t_addr[(i-1) % 5], addr_out);
      if (i >= 1) chk("dqs_oe", 2'h3, dqs_oe);
      wr_valid = (i < 5) ? t_val[i % 5] : 1'b0;
      rise_in = t_rise[i % 5];
      fall_in = t_fall[i % 5];
      mr = t_mr[i % 5];
      mf = t_mf[i % 5];
      addr_in = t_addr[i % 5];
      @(negedge core_clk);
    end
    wait_n(4);
    chk("dq_oe_end", 2'h0, dq_oe);
    chk("dqs_oe_end", 2'h0, dqs_oe);
    chk("partner_word", mk(t_rise[4], t_fall[4]), cap_word);
    // input capture: basic, enable hold, full transfer, dynamic delay, geared
    send(8'hA5, 8'h3C, 8);
    chk("rise_q", 8'hA5, rq);
    chk("fall_q", 8'h3C, fq);
    in_ce = 1'b0;
    send(8'h5A, 8'hC3, 8);
    chk("rise_q_held", 8'hA5, rq);
    in_ce = 1'b1;
    wait_n(8);
    chk("fall_q", 8'hC3, fq);
    in_mode = IN_FULL;
    send(8'h0F, 8'hF0, 8);
    chk("rise_q_full", 8'h0F, rq);
    chk("fall_q_full", 8'hF0, fq);
    dyn = 1'b1;
    dcode = 4'hF;
    // let the delay line fill with the current word before the next one arrives
    wait_n(20);
    send(8'h81, 8'h18, 8);
    chk("rise_q_delayed", 8'h0F, rq);
    wait_n(20);
    chk("rise_q_late", 8'h81, rq);
    dyn = 1'b0;
    in_mode = IN_GEARED;
    send(8'h66, 8'h99, 12);
    chk("rise_pair", {8'h66, 8'h66}, rqp);
    chk("fall_pair", {8'h99, 8'h99}, fqp);
    send_en = 1'b0;
    // geared output: four core words leave as two pin periods
    gin = {8'h44, 8'h33, 8'h22, 8'h11};
    k = 0;
    while (slow_tick !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    @(negedge core_clk);
    chk("gear_first", mk(8'h11, 8'h22), gear_out);
    chk("slow_low", 1'b0, slow_tick);
    @(negedge core_clk);
    chk("gear_second", mk(8'h33, 8'h44), gear_out);
    chk("slow_high", 1'b1, slow_tick);
    // reset in mid-run clears capture and launch registers
    reset = 1'b1;
    wait_n(2);
    chk("rise_q_rst", 8'h00, rq);
    chk("rise_pair_rst", 16'h0000, rqp);
    chk("dq_out_rst", 16'h0000, dq_out);
    chk("gear_rst", 16'h0000, gear_out);
    reset = 1'b0;
    wait_n(2);
    summarize();
  end
endmodule

// File: verilog/ddrio_pkg.sv
// shared constants and carrier types for the ddr i/o register logic
package ddrio_pkg;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int DELAY_STEP_PS = 35;
  // a quarter period in delay steps, rounded down
  localparam logic [7:0] STROBE_QUARTER_CODE = 8'(CLK_PERIOD_PS / 4 / DELAY_STEP_PS);
  localparam int DLY_CODE_W = 4;
  localparam int DLY_TAPS = 1 << DLY_CODE_W;
  // ***********************************************************
  // levels of the strobe and memory clock output register
  // ***********************************************************
  localparam logic STROBE_FALL_LEVEL = 1'b1;
  localparam logic STROBE_RISE_LEVEL = 1'b0;
  // ***********************************************************
  // types
  // ***********************************************************
  // one pin bit over one clock period: value after rise, value after fall
  typedef struct packed {
    logic fall;
    logic rise;
  } ddrio_pair_s;
  typedef enum logic [2:0] {
    IN_BASIC = 3'h1,
    IN_FULL = 3'h2,
    IN_GEARED = 3'h4
  } ddrio_in_mode_e;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_ACTIVE = 2'h2
  } ddrio_wr_state_e;
endpackage

// File: verilog/ddrio_top.sv
// ddr i/o register logic: memory write path, generic ddr input and geared output
//
// Operation
// - write path muxes two streams onto pin
// - strobe centred on each data window
// - also drive memory clocks, address, mask
// - address, command, strobe aligned to clock
// - all outputs start from core clock
// - strobe/clock register: fall high, rise low
// - negative clock from same register, inverted
// - data captured, then shifted out later
// - inverted transfer clock centres data
// - strobe and positive clock same phase
// - output enables use ddr output register
// - one dll setting per chip half
// - half/full transfer, x1/x2 gearing
// - 2x: four core bits per two
// - optional fixed or dynamic input delay
// - basic input: rise and fall outputs
// - clock enable and reset on inputs
// - full transfer delivers on transfer clock
// - transfer stage after capture stage
// - slow clock exactly half edge clock
// - geared input: slow third stage
// - geared output serialises four streams
// - ddr output register edge ordering
`timescale 1ns/1ps
module ddrio_top #(
  parameter int DW = 8,
  parameter int AW = 16,
  parameter logic [ddrio_pkg::DLY_CODE_W-1:0] FIXED_DELAY = '0
) (
  input logic core_clk,
  input logic reset,
  input logic wr_valid,
  input logic [DW-1:0] rise_edge_data_in,
  input logic [DW-1:0] fall_edge_data_in,
  input logic mask_rise_in,
  input logic mask_fall_in,
  input logic [AW-1:0] addr_cmd_in,
  output ddrio_pkg::ddrio_pair_s [DW-1:0] dq_out,
  output ddrio_pkg::ddrio_pair_s dq_oe,
  output ddrio_pkg::ddrio_pair_s dm_out,
  output ddrio_pkg::ddrio_pair_s dqs_out,
  output ddrio_pkg::ddrio_pair_s dqs_oe,
  output ddrio_pkg::ddrio_pair_s mem_clock_pos,
  output ddrio_pkg::ddrio_pair_s mem_clock_neg,
  output logic [AW-1:0] addr_cmd_out,
  output logic [7:0] strobe_delay_setting,
  input ddrio_pkg::ddrio_pair_s [DW-1:0] in_pin,
  input logic in_ce,
  input ddrio_pkg::ddrio_in_mode_e in_mode,
  input logic delay_dynamic,
  input logic [ddrio_pkg::DLY_CODE_W-1:0] delay_code,
  output logic [DW-1:0] rise_data_out,
  output logic [DW-1:0] fall_data_out,
  output logic [1:0][DW-1:0] rise_data_out_pair,
  output logic [1:0][DW-1:0] fall_data_out_pair,
  input logic [3:0][DW-1:0] gear_data_in,
  output ddrio_pkg::ddrio_pair_s [DW-1:0] gear_out,
  output logic slow_tick
);
  import ddrio_pkg::*;

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  if (DW < 1 || DW > 64) begin : g_dw_bad
    $error("DW must be 1 to 64");
  end
  if (AW < 1) begin : g_aw_bad
    $error("AW must be at least 1");
  end

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    ddrio_wr_state_e wst;
    logic slow_ph;
    logic [7:0] dll_code;
    logic [DW-1:0] wr_r1;
    logic [DW-1:0] wr_f1;
    logic [DW-1:0] wr_r2;
    logic [DW-1:0] wr_f2;
    logic [1:0] m1;
    logic [1:0] m2;
    logic v1;
    logic v2;
    logic [AW-1:0] ac;
    ddrio_pair_s [DW-1:0] s1;
    ddrio_pair_s [DW-1:0] s2;
    ddrio_pair_s [DW-1:0] s3;
    ddrio_pair_s [DW-1:0] filt;
    ddrio_pair_s [DLY_TAPS-2:0][DW-1:0] dly;
    ddrio_pair_s [DW-1:0] cap;
    ddrio_pair_s [DW-1:0] ghold;
    ddrio_pair_s [DW-1:0] gnext;
    ddrio_pair_s [DW-1:0] gout;
    logic [DW-1:0] q_rise;
    logic [DW-1:0] q_fall;
    logic [1:0][DW-1:0] qr_pair;
    logic [1:0][DW-1:0] qf_pair;
  } ddrio_state_s;

  ddrio_state_s st_r;
  ddrio_state_s st_nxt;
  ddrio_pair_s [DW-1:0] delayed;
  logic [DLY_CODE_W-1:0] dly_sel;

  // ddr output edge order
  // two-input ddr output register: fall input after falling edge, rise after rising
  function automatic ddrio_pair_s [DW-1:0] ddr_pack(input logic [DW-1:0] fall_v,
                                                     input logic [DW-1:0] rise_v);
    ddrio_pair_s [DW-1:0] p;
    for (int i = 0; i < DW; i++) begin
      p[i].fall = fall_v[i];
      p[i].rise = rise_v[i];
    end
    return p;
  endfunction

  // split a pin word into its rise or fall half
  function automatic logic [DW-1:0] half_of(input ddrio_pair_s [DW-1:0] p, input logic fall);
    logic [DW-1:0] v;
    for (int i = 0; i < DW; i++) begin
      v[i] = fall ? p[i].fall : p[i].rise;
    end
    return v;
  endfunction

  // ***********************************************************
  // input delay tap
  // ***********************************************************
  // fixed or dynamic delay
  assign dly_sel = delay_dynamic ? delay_code : FIXED_DELAY;
  assign delayed = (dly_sel == '0) ? st_r.filt : st_r.dly[int'(dly_sel) - 1];

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    st_nxt = st_r;
    // slow rate is every second cycle
    st_nxt.slow_ph = ~st_r.slow_ph;
    // capture core data first, shift out one stage later
    st_nxt.wr_r1 = rise_edge_data_in;
    st_nxt.wr_f1 = fall_edge_data_in;
    st_nxt.m1 = {mask_fall_in, mask_rise_in};
    st_nxt.v1 = wr_valid;
    st_nxt.wr_r2 = st_r.wr_r1;
    st_nxt.wr_f2 = st_r.wr_f1;
    st_nxt.m2 = st_r.m1;
    st_nxt.v2 = st_r.v1;
    // address and command launched with the clock rise
    st_nxt.ac = addr_cmd_in;
    // strobe stays enabled from one cycle before data until one cycle after data ends
    case (st_r.wst)
      WR_IDLE: begin
        if (wr_valid) begin
          st_nxt.wst = WR_ACTIVE;
        end
      end
      WR_ACTIVE: begin
        if (!wr_valid && !st_r.v1 && !st_r.v2) begin
          st_nxt.wst = WR_IDLE;
        end
      end
      default: begin
        st_nxt.wst = WR_IDLE;
      end
    endcase
    // pin input: three flops, a change counts once stages two and three agree
    st_nxt.s1 = in_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < DW; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
    st_nxt.dly[0] = st_r.filt;
    for (int k = 1; k < DLY_TAPS - 1; k++) begin
      st_nxt.dly[k] = st_r.dly[k-1];
    end
    // clock enable gates every capture stage
    if (in_ce) begin
      st_nxt.cap = delayed;
      // mode selects half, full transfer or 2x gearing
      case (in_mode)
        IN_BASIC: begin
          // rise and fall halves on separate outputs
          st_nxt.q_rise = half_of(delayed, 1'b0);
          st_nxt.q_fall = half_of(delayed, 1'b1);
        end
        IN_FULL: begin
          // transfer stage fed from capture stage
          st_nxt.q_rise = half_of(st_r.cap, 1'b0);
          st_nxt.q_fall = half_of(st_r.cap, 1'b1);
        end
        IN_GEARED: begin
          // hold first word, slow stage takes both
          if (!st_r.slow_ph) begin
            st_nxt.ghold = delayed;
          end else begin
            st_nxt.qr_pair = {half_of(delayed, 1'b0), half_of(st_r.ghold, 1'b0)};
            st_nxt.qf_pair = {half_of(delayed, 1'b1), half_of(st_r.ghold, 1'b1)};
          end
        end
        default: begin
          st_nxt.q_rise = '0;
          st_nxt.q_fall = '0;
        end
      endcase
    end
    // four streams loaded on the slow tick, sent over two cycles
    if (st_r.slow_ph) begin
      st_nxt.gout = ddr_pack(gear_data_in[1], gear_data_in[0]);
      st_nxt.gnext = ddr_pack(gear_data_in[3], gear_data_in[2]);
    end else begin
      st_nxt.gout = st_r.gnext;
    end
    // synchronous reset clears everything except the write state (set to idle) and the dll code (set to the quarter code), regardless of enable
    if (reset) begin
      st_nxt = '0;
      st_nxt.wst = WR_IDLE;
      st_nxt.dll_code = STROBE_QUARTER_CODE;
    end
  end

  // every output from core clock
  // single register for all state
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // two single-rate streams become one ddr pin stream
  assign dq_out = ddr_pack(st_r.wr_f2, st_r.wr_r2);
  // data mask goes out with the data
  assign dm_out = ddrio_pair_s'{fall: st_r.m2[1], rise: st_r.m2[0]};
  // data enable through the same ddr register form
  assign dq_oe = ddrio_pair_s'{fall: st_r.v2, rise: st_r.v2};
  // fall input tied high, rise input tied low
  assign dqs_out = ddrio_pair_s'{fall: STROBE_FALL_LEVEL, rise: STROBE_RISE_LEVEL};
  // strobe enabled around the whole data window
  assign dqs_oe = ddrio_pair_s'{fall: st_r.wst == WR_ACTIVE, rise: st_r.wst == WR_ACTIVE};
  // positive clock shares the strobe waveform
  assign mem_clock_pos = dqs_out;
  // negative clock is the same register through a differential buffer
  assign mem_clock_neg = ~mem_clock_pos;
  assign addr_cmd_out = st_r.ac;
  // one quarter-period setting for every strobe delay block
  assign strobe_delay_setting = st_r.dll_code;
  assign rise_data_out = st_r.q_rise;
  assign fall_data_out = st_r.q_fall;
  assign rise_data_out_pair = st_r.qr_pair;
  assign fall_data_out_pair = st_r.qf_pair;
  assign gear_out = st_r.gout;
  // one slow tick every two pin-rate cycles
  assign slow_tick = st_r.slow_ph;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence tick_seq;
    slow_tick ##1 !slow_tick ##1 slow_tick;
  endsequence

  data_mux_a: assert property (
    (!$past(reset) && !$past(reset, 2)) |->
      dq_out == ddr_pack($past(fall_edge_data_in, 2), $past(rise_edge_data_in, 2)))
    else $error("ddr data word not the core pair two cycles back");
  strobe_clk_a: assert property (
    mem_clock_pos == dqs_out && dqs_out.fall && !dqs_out.rise)
    else $error("strobe and memory clock differ or wrong shape");
  clk_neg_a: assert property (
    mem_clock_neg == ~mem_clock_pos)
    else $error("negative memory clock not the inverse");
  dq_oe_a: assert property (
    (!$past(reset) && !$past(reset, 2)) |-> dq_oe == {2{$past(wr_valid, 2)}})
    else $error("data enable not two cycles after write valid");
  strobe_window_a: assert property (
    (dq_oe != 2'h0) |-> (dqs_oe == 2'h3 && $past(dqs_oe) == 2'h3))
    else $error("strobe not enabled around data");
  addr_align_a: assert property (
    !$past(reset) |-> addr_cmd_out == $past(addr_cmd_in))
    else $error("address not launched one cycle after input");
  reset_clear_a: assert property (@(posedge core_clk) disable iff (1'b0)
    $past(reset) |-> (rise_data_out == '0 && fall_data_out == '0 && gear_out == '0))
    else $error("registers not cleared by reset");
  ce_hold_a: assert property (
    !in_ce |=> ($stable(rise_data_out) && $stable(fall_data_out)))
    else $error("input outputs changed without clock enable");
  gear_tick_a: assert property (
    slow_tick |-> tick_seq)
    else $error("slow tick not every second cycle");
  basic_cap_a: assert property (
    (in_ce && in_mode == IN_BASIC) |=>
      rise_data_out == half_of($past(delayed), 1'b0))
    else $error("basic capture missed rise data");
endmodule
